// [rtl/pcs_stat_pkg.sv]
// shared constants and types for the pcs status and test-pattern block
package pcs_stat_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;            // 200 mhz system clock
  localparam int BER_WINDOW_NS = 125000;          // bit error rate window
  localparam int BER_WINDOW_CYC = (BER_WINDOW_NS * 1000) / CLK_PERIOD_PS;
  localparam int BER_LIMIT = 16;                  // bad headers per window
  localparam int PPM_TOLERANCE = 200;             // offset the fifo absorbs
  localparam int BER_CNT_W = 16;                  // window counter width

  // ----------------------------------------------------------------
  // block and scrambler
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int BLOCK_W = 64;
  localparam int SCR_W = 58;
  localparam int SCR_TAP_A = 38;
  localparam int SCR_TAP_B = 57;
  localparam logic [SCR_W-1:0] SCR_SEED = 58'h3ff_ffff_ffff_ffff;
  localparam logic [BLOCK_W-1:0] IDLE_BLOCK = 64'h0000_0000_0000_001e;
  localparam logic [BLOCK_W-1:0] FAULT_BLOCK = 64'h0100_0000_0000_0055;
  localparam logic [1:0] LANE_TWO = 2'h2;
  localparam logic [1:0] LANE_THREE = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LIVE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MISMATCH_TOTAL = 8'h14;
  localparam int CTRL_TX_TEST = 0;
  localparam int CTRL_RX_TEST = 1;
  localparam int CTRL_W = 2;
  localparam int LIVE_FIFO = 0;
  localparam int LIVE_FAULT = 1;
  localparam int LIVE_BER = 2;
  localparam int LIVE_LOCK_LSB = 4;
  localparam int EVT_FIFO = 0;
  localparam int EVT_FAULT = 1;
  localparam int EVT_BER = 2;
  localparam int EVT_LOCK_LOST = 3;
  localparam int EVT_MISMATCH = 4;
  localparam int EVT_W = 5;

  // checker states
  typedef enum logic [2:0] {
    CHK_IDLE = 3'h1,
    CHK_SYNC = 3'h2,
    CHK_RUN  = 3'h4
  } chk_state_type;

endpackage : pcs_stat_pkg

// [rtl/scrambled_idle_lane.sv]
// scrambler or self-synchronising descrambler for one 64-bit block stream
module scrambled_idle_lane #(
  parameter bit DESCRAMBLE = 1'b0                  // 1: descramble
) (
  input  wire logic                               i_clk_sys, // system clock
  input  wire logic                               i_rstn,    // async reset
  input  wire logic                               i_clear,   // reload seed
  input  wire logic                               i_advance, // take a word
  input  wire logic [pcs_stat_pkg::BLOCK_W-1:0]   i_data,    // word in
  output logic      [pcs_stat_pkg::BLOCK_W-1:0]   o_data     // word out
);

  typedef struct packed {
    logic [pcs_stat_pkg::SCR_W-1:0]   hist;
    logic [pcs_stat_pkg::BLOCK_W-1:0] data;
  } lane_state_type;

  lane_state_type cur;
  lane_state_type next_cur;

  // one block through x^58 + x^39 + 1, history newest in bit 0
  function automatic logic [pcs_stat_pkg::SCR_W+pcs_stat_pkg::BLOCK_W-1:0] step(
    input logic [pcs_stat_pkg::BLOCK_W-1:0] din,
    input logic [pcs_stat_pkg::SCR_W-1:0]   h
  );
    logic [pcs_stat_pkg::SCR_W-1:0]   s;
    logic [pcs_stat_pkg::BLOCK_W-1:0] o;
    s = h;
    o = '0;
    for (int i = 0; i < pcs_stat_pkg::BLOCK_W; i++)
    begin
      o[i] = din[i] ^ s[pcs_stat_pkg::SCR_TAP_A] ^ s[pcs_stat_pkg::SCR_TAP_B];
      s = {s[pcs_stat_pkg::SCR_W-2:0], (DESCRAMBLE ? din[i] : o[i])};
    end
    return {s, o};
  endfunction : step

  // next state: clear primes the first word from the seed
  always_comb
  begin
    next_cur = cur;
    if (i_clear)
    begin
      // keep the advanced history so the next word continues the sequence
      {next_cur.hist, next_cur.data} = step(i_data, pcs_stat_pkg::SCR_SEED);
    end
    else if (i_advance)
    begin
      {next_cur.hist, next_cur.data} = step(i_data, cur.hist);
    end
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      cur <= '{hist: pcs_stat_pkg::SCR_SEED, data: '0};
    else
      cur <= next_cur;
  end

  assign o_data = cur.data;

endmodule : scrambled_idle_lane

// [rtl/pcs_rx_status_test_pattern.sv]
// pcs receive status, test-pattern generator/checker and register port
// How it works
// - tx test enable sends scrambled idle; third after markers and fault.
// - rx test enable checks scrambled idle; third after fault and lock.
// - compensation fifo error goes high on fifo underflow or overflow.
// - fifo tolerates 200 ppm; only real slips raise the error.
// - local fault is high while the decoder sits in its init state.
// - excess bit errors goes high when a window's bad header count reaches the limit.
// - four lock bits, one per lane, high while that lane holds lock.
// - eight-bit mismatch increment each cycle, zero when none.
// - mismatch increment stays zero unless rx test enable is set.
// - each nonzero increment stands for exactly one cycle.
// - lane 2 and 3 alignment markers come from static inputs.
// - all rx status and rx test enable run on the one core clock.
module pcs_rx_status_test_pattern #(
  parameter int unsigned BER_WINDOW_CYC = pcs_stat_pkg::BER_WINDOW_CYC, // window
  parameter int unsigned BER_LIMIT      = pcs_stat_pkg::BER_LIMIT       // limit
) (
  input  wire logic        i_clk_sys,              // 200 mhz clock
  input  wire logic        i_rstn,                 // async reset, low
  input  wire logic [7:0]  i_addr,                 // register address
  input  wire logic [31:0] i_wdata,                // write data
  input  wire logic        i_wr,                   // write strobe
  input  wire logic        i_rd,                   // read strobe
  output logic      [31:0] o_rdata,                // read data, next cycle
  output logic             o_irq,                  // level interrupt
  input  wire logic        i_rx_fifo_underflow,    // comp fifo ran dry
  input  wire logic        i_rx_fifo_overflow,     // comp fifo overran
  input  wire logic        i_rx_decoder_init,      // decoder in init state
  input  wire logic        i_rx_sync_hdr_valid,    // one header seen
  input  wire logic        i_rx_sync_hdr_bad,      // that header was bad
  input  wire logic [3:0]  i_rx_lane_lock,         // per-lane block lock
  input  wire logic [63:0] i_rx_block,             // received block
  input  wire logic        i_rx_block_valid,       // block strobe
  input  wire logic [63:0] i_tx_block,             // user tx block
  input  wire logic        i_tx_block_valid,       // user tx strobe
  input  wire logic        i_tx_force_fault,       // send fault blocks
  input  wire logic        i_tx_marker_slot,       // marker slot now
  input  wire logic [1:0]  i_tx_lane,              // lane of this slot
  input  wire logic [63:0] i_tx_lane2_align_marker, // static lane 2 marker
  input  wire logic [63:0] i_tx_lane3_align_marker, // static lane 3 marker
  output logic [63:0]      o_tx_block,             // tx block out
  output logic             o_tx_block_valid,       // tx block strobe
  output logic             o_rx_fifo_error,        // sticky fifo error
  output logic             o_rx_local_fault,       // decoder in init
  output logic             o_rx_excess_bit_errors, // error rate too high
  output logic [3:0]       o_rx_lane_lock,         // lane lock levels
  output logic [7:0]       o_rx_mismatch_count     // mismatch increment
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (BER_WINDOW_CYC < 2 || BER_WINDOW_CYC >= (1 << pcs_stat_pkg::BER_CNT_W))
  begin : g_bad_window
    $error("ber window out of range");
  end
  if (BER_LIMIT < 1 || BER_LIMIT > 255)
  begin : g_bad_limit
    $error("ber limit out of range");
  end

  localparam logic [15:0] WIN_LAST = 16'(BER_WINDOW_CYC - 1);
  localparam logic [7:0] LIMIT = 8'(BER_LIMIT);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [pcs_stat_pkg::CTRL_W-1:0] ctrl;
    logic [pcs_stat_pkg::EVT_W-1:0]  evt_status;
    logic [pcs_stat_pkg::EVT_W-1:0]  evt_enable;
    logic [31:0]                     mismatch_total;
    logic                            fifo_err;
    logic                            local_fault;
    logic                            excess_ber;
    logic [3:0]                      lane_lock;
    logic [15:0]                     ber_win;
    logic [7:0]                      bad_cnt;
    pcs_stat_pkg::chk_state_type     chk;
    logic                            desc_valid;
    logic [7:0]                      mismatch;
    logic [63:0]                     tx_block;
    logic                            tx_valid;
    logic [31:0]                     rdata;
    logic                            irq;
  } state_type;

  state_type   cur;
  state_type   next_cur;
  logic [63:0] gen_data;
  logic [63:0] desc_data;
  logic        chk_ok;
  logic        tx_marker23;

  // count of set bits in a block
  function automatic logic [7:0] count_ones(input logic [63:0] v);
    logic [7:0] n;
    n = '0;
    for (int i = 0; i < 64; i++)
      n = n + 8'(v[i]);
    return n;
  endfunction : count_ones

  // ----------------------------------------------------------------
  // pattern generator and checker lanes
  // ----------------------------------------------------------------
  // tx generator primed from the seed while test mode is off
  scrambled_idle_lane #(.DESCRAMBLE(1'b0)) u_gen (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_clear   (!cur.ctrl[pcs_stat_pkg::CTRL_TX_TEST]),
    .i_advance (i_tx_block_valid && !tx_marker23 && !i_tx_force_fault),
    .i_data    (pcs_stat_pkg::IDLE_BLOCK),
    .o_data    (gen_data)
  );

  // rx descrambler flushed while the checker is idle
  scrambled_idle_lane #(.DESCRAMBLE(1'b1)) u_chk (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_clear   (cur.chk == pcs_stat_pkg::CHK_IDLE),
    .i_advance (i_rx_block_valid),
    .i_data    (i_rx_block),
    .o_data    (desc_data)
  );

  assign tx_marker23 = i_tx_marker_slot &&
                       (i_tx_lane == pcs_stat_pkg::LANE_TWO ||
                        i_tx_lane == pcs_stat_pkg::LANE_THREE);
  // checking ranks below decoder init and missing lane lock
  assign chk_ok = cur.ctrl[pcs_stat_pkg::CTRL_RX_TEST] && !i_rx_decoder_init &&
                  (&i_rx_lane_lock);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [pcs_stat_pkg::EVT_W-1:0] evt;
    logic [pcs_stat_pkg::EVT_W-1:0] clr;
    logic [7:0]                     bad_now;
    evt = '0;
    clr = '0;
    bad_now = '0;
    next_cur = cur;

    // receive status, all on the one core clock
    // sticky until reset; only real slips set it
    next_cur.fifo_err = cur.fifo_err || i_rx_fifo_underflow || i_rx_fifo_overflow;
    next_cur.local_fault = i_rx_decoder_init;
    next_cur.lane_lock = i_rx_lane_lock;

    // bad header count over a fixed window
    bad_now = cur.bad_cnt;
    if (i_rx_sync_hdr_valid && i_rx_sync_hdr_bad && cur.bad_cnt != LIMIT)
      bad_now = cur.bad_cnt + 8'h01;
    next_cur.bad_cnt = bad_now;
    next_cur.ber_win = cur.ber_win + 16'h0001;
    if (bad_now == LIMIT)
      next_cur.excess_ber = 1'b1;
    if (cur.ber_win == WIN_LAST)
    begin
      next_cur.excess_ber = (bad_now == LIMIT);
      next_cur.bad_cnt = '0;
      next_cur.ber_win = '0;
    end

    // checker: idle, discard one block to resync, then compare
    case (cur.chk)
      pcs_stat_pkg::CHK_IDLE:
        if (chk_ok)
          next_cur.chk = pcs_stat_pkg::CHK_SYNC;
      pcs_stat_pkg::CHK_SYNC:
        if (!chk_ok)
          next_cur.chk = pcs_stat_pkg::CHK_IDLE;
        else if (i_rx_block_valid)
          next_cur.chk = pcs_stat_pkg::CHK_RUN;
      pcs_stat_pkg::CHK_RUN:
        if (!chk_ok)
          next_cur.chk = pcs_stat_pkg::CHK_IDLE;
      default:
        next_cur.chk = pcs_stat_pkg::CHK_IDLE;
    endcase
    next_cur.desc_valid = i_rx_block_valid && chk_ok &&
                          cur.chk == pcs_stat_pkg::CHK_RUN;

    // increment stands one cycle, zero otherwise
    next_cur.mismatch = '0;
    if (cur.desc_valid && chk_ok)
      next_cur.mismatch = count_ones(desc_data ^ pcs_stat_pkg::IDLE_BLOCK);
    if (cur.mismatch_total != 32'hffff_ffff)
      next_cur.mismatch_total = cur.mismatch_total + 32'(cur.mismatch);

    // tx source: markers, fault, test pattern, user data
    next_cur.tx_valid = i_tx_block_valid;
    if (i_tx_block_valid)
    begin
      // markers are static while the path runs
      if (tx_marker23)
        next_cur.tx_block = (i_tx_lane == pcs_stat_pkg::LANE_TWO) ?
                            i_tx_lane2_align_marker : i_tx_lane3_align_marker;
      else if (i_tx_force_fault)
        next_cur.tx_block = pcs_stat_pkg::FAULT_BLOCK;
      else if (cur.ctrl[pcs_stat_pkg::CTRL_TX_TEST])
        next_cur.tx_block = gen_data;
      else
        next_cur.tx_block = i_tx_block;
    end

    // events into sticky status, set wins over clear
    evt[pcs_stat_pkg::EVT_FIFO] = next_cur.fifo_err && !cur.fifo_err;
    evt[pcs_stat_pkg::EVT_FAULT] = next_cur.local_fault && !cur.local_fault;
    evt[pcs_stat_pkg::EVT_BER] = next_cur.excess_ber && !cur.excess_ber;
    evt[pcs_stat_pkg::EVT_LOCK_LOST] = |(cur.lane_lock & ~next_cur.lane_lock);
    evt[pcs_stat_pkg::EVT_MISMATCH] = next_cur.mismatch != '0;
    if (i_wr && i_addr == pcs_stat_pkg::OFF_EVT_CLEAR)
      clr = i_wdata[pcs_stat_pkg::EVT_W-1:0];
    next_cur.evt_status = (cur.evt_status & ~clr) | evt;

    // register writes
    if (i_wr && i_addr == pcs_stat_pkg::OFF_CTRL)
      next_cur.ctrl = i_wdata[pcs_stat_pkg::CTRL_W-1:0];
    if (i_wr && i_addr == pcs_stat_pkg::OFF_EVT_ENABLE)
      next_cur.evt_enable = i_wdata[pcs_stat_pkg::EVT_W-1:0];

    // register reads, data only in the cycle after the strobe
    next_cur.rdata = '0;
    if (i_rd)
    begin
      case (i_addr)
        pcs_stat_pkg::OFF_CTRL:
          next_cur.rdata = 32'(cur.ctrl);
        pcs_stat_pkg::OFF_LIVE:
        begin
          next_cur.rdata[pcs_stat_pkg::LIVE_FIFO] = cur.fifo_err;
          next_cur.rdata[pcs_stat_pkg::LIVE_FAULT] = cur.local_fault;
          next_cur.rdata[pcs_stat_pkg::LIVE_BER] = cur.excess_ber;
          next_cur.rdata[pcs_stat_pkg::LIVE_LOCK_LSB +: 4] = cur.lane_lock;
        end
        pcs_stat_pkg::OFF_EVT_STATUS:
          next_cur.rdata = 32'(cur.evt_status);
        pcs_stat_pkg::OFF_EVT_ENABLE:
          next_cur.rdata = 32'(cur.evt_enable);
        pcs_stat_pkg::OFF_MISMATCH_TOTAL:
          next_cur.rdata = cur.mismatch_total;
        default:
          next_cur.rdata = '0;
      endcase
    end

    next_cur.irq = |(next_cur.evt_status & next_cur.evt_enable);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cur <= '0;
      cur.chk <= pcs_stat_pkg::CHK_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign o_rdata = cur.rdata;
  assign o_irq = cur.irq;
  assign o_tx_block = cur.tx_block;
  assign o_tx_block_valid = cur.tx_valid;
  assign o_rx_fifo_error = cur.fifo_err;
  assign o_rx_local_fault = cur.local_fault;
  assign o_rx_excess_bit_errors = cur.excess_ber;
  assign o_rx_lane_lock = cur.lane_lock;
  assign o_rx_mismatch_count = cur.mismatch;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_TX_TEST: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_tx_block_valid && !tx_marker23 && !i_tx_force_fault &&
    cur.ctrl[pcs_stat_pkg::CTRL_TX_TEST] |=> o_tx_block == $past(gen_data))
    else $error("tx test pattern not sent");

  AST_CHK_GATED: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !chk_ok |=> cur.chk == pcs_stat_pkg::CHK_IDLE ##1 !cur.desc_valid)
    else $error("checker ran without enable");

  AST_FIFO_STICKY: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_rx_fifo_underflow || i_rx_fifo_overflow) |=> o_rx_fifo_error [*3])
    else $error("fifo error not held");

  AST_FAULT_LEVEL: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    1'b1 |=> o_rx_local_fault == $past(i_rx_decoder_init))
    else $error("local fault does not follow decoder init");

  AST_BER_CAUSE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_rx_excess_bit_errors) |-> $past(i_rx_sync_hdr_valid && i_rx_sync_hdr_bad)
      || $past(cur.ber_win) == WIN_LAST)
    else $error("excess bit errors rose without bad header");

  AST_LOCK_FOLLOW: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_rx_lane_lock != $past(i_rx_lane_lock) |=> o_rx_lane_lock != $past(o_rx_lane_lock))
    else $error("lane lock did not follow");

  AST_MM_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !cur.ctrl[pcs_stat_pkg::CTRL_RX_TEST] [*2] |-> o_rx_mismatch_count == 8'h00)
    else $error("mismatch count while test off");

  AST_MM_CAUSE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_rx_mismatch_count != 8'h00 |-> $past(i_rx_block_valid, 2) && $past(cur.desc_valid))
    else $error("mismatch count without a block");

  AST_TX_MARKER: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_tx_block_valid && i_tx_marker_slot && i_tx_lane == pcs_stat_pkg::LANE_TWO
      |=> o_tx_block == $past(i_tx_lane2_align_marker) && o_tx_block_valid)
    else $error("lane 2 marker not inserted");

  AST_RESTART: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    cur.chk == pcs_stat_pkg::CHK_IDLE |=> ##1 o_rx_mismatch_count == 8'h00)
    else $error("mismatch reported during restart");

  CVR_MISMATCH: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_rx_mismatch_count != 8'h00);
  CVR_TX_TEST: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    cur.ctrl[pcs_stat_pkg::CTRL_TX_TEST] && o_tx_block_valid);
  CVR_BER: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(o_rx_excess_bit_errors));
  CVR_IRQ: cover property (@(posedge i_clk_sys) disable iff (!i_rstn) $rose(o_irq));

endmodule : pcs_rx_status_test_pattern

// [verif/pcs_link_model.sv]
// far-side lane model: scrambled idle block stream with bit error injection
module pcs_link_model (
  input  wire logic        i_clk_sys, // system clock
  input  wire logic        i_en,      // stream running
  input  wire logic [63:0] i_err,     // bits flipped on the line
  output logic      [63:0] o_block,   // scrambled block
  output logic             o_valid    // block strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [57:0] state = '1;
  initial o_block = 64'h0;
  initial o_valid = 1'b0;
  // scramble one word lsb first, returns {state, word}
  function automatic logic [121:0] scramble(input logic [63:0] d, input logic [57:0] s);
    logic [63:0] q;
    for (int i = 0; i < 64; i++)
    begin
      q[i] = d[i] ^ s[38] ^ s[57];
      s    = {s[56:0], q[i]};
    end
    return {s, q};
  endfunction : scramble
  // released line alternates each cycle between the last block and its inverse
  always @(posedge i_clk_sys)
  begin
    if (i_en)
    begin
      {state, o_block} <= scramble(pcs_stat_pkg::IDLE_BLOCK, state) ^ {58'h0, i_err};
      o_valid          <= 1'b1;
    end
    else
    begin
      o_block <= ~o_block;
      o_valid <= 1'b0;
    end
  end
endmodule : pcs_link_model

// [verif/test_pcs_rx_status_test_pattern.sv]
// self-checking bench for the pcs status and test-pattern block
module test_pcs_rx_status_test_pattern;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk_sys = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
  logic [7:0]  i_addr = 8'h00, o_rx_mismatch_count;
  logic [31:0] i_wdata = 32'h0, o_rdata, rdv;
  logic        i_rx_fifo_underflow = 1'b0, i_rx_fifo_overflow = 1'b0, i_rx_decoder_init = 1'b1;
  logic        i_rx_sync_hdr_valid = 1'b0, i_rx_sync_hdr_bad = 1'b0, i_rx_block_valid;
  logic        i_tx_block_valid = 1'b0, i_tx_force_fault = 1'b0, i_tx_marker_slot = 1'b0;
  logic        o_tx_block_valid, o_rx_fifo_error, o_rx_local_fault, o_rx_excess_bit_errors;
  logic [3:0]  i_rx_lane_lock = 4'h0, o_rx_lane_lock, lk;
  logic [1:0]  i_tx_lane = 2'h0;
  logic [63:0] i_rx_block, i_tx_block = 64'h0, o_tx_block, err = 64'h0, w;
  logic [63:0] i_tx_lane2_align_marker, i_tx_lane3_align_marker;
  logic        link_en = 1'b0;
  logic [57:0] gen = pcs_stat_pkg::SCR_SEED;
  logic [6:0]  gate [3] = '{7'h0f, 7'h5f, 7'h47};
  int          bad_count = 0, checked = 0, hits = 0, sum = 0, exp_hits = 0, exp_sum = 0;

  pcs_rx_status_test_pattern #(.BER_WINDOW_CYC(64), .BER_LIMIT(16)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_rx_fifo_underflow(i_rx_fifo_underflow), .i_rx_fifo_overflow(i_rx_fifo_overflow),
    .i_rx_decoder_init(i_rx_decoder_init), .i_rx_sync_hdr_valid(i_rx_sync_hdr_valid),
    .i_rx_sync_hdr_bad(i_rx_sync_hdr_bad), .i_rx_lane_lock(i_rx_lane_lock),
    .i_rx_block(i_rx_block), .i_rx_block_valid(i_rx_block_valid), .i_tx_block(i_tx_block),
    .i_tx_block_valid(i_tx_block_valid), .i_tx_force_fault(i_tx_force_fault),
    .i_tx_marker_slot(i_tx_marker_slot), .i_tx_lane(i_tx_lane),
    .i_tx_lane2_align_marker(i_tx_lane2_align_marker),
    .i_tx_lane3_align_marker(i_tx_lane3_align_marker), .o_tx_block(o_tx_block),
    .o_tx_block_valid(o_tx_block_valid), .o_rx_fifo_error(o_rx_fifo_error),
    .o_rx_local_fault(o_rx_local_fault), .o_rx_excess_bit_errors(o_rx_excess_bit_errors),
    .o_rx_lane_lock(o_rx_lane_lock), .o_rx_mismatch_count(o_rx_mismatch_count));
  pcs_link_model i_link (.i_clk_sys(i_clk_sys), .i_en(link_en), .i_err(err),
    .o_block(i_rx_block), .o_valid(i_rx_block_valid));

  always #2.5 i_clk_sys = ~i_clk_sys;
  // tally every nonzero increment
  always @(negedge i_clk_sys)
    if (o_rx_mismatch_count !== 8'h00)
    begin
      hits++;
      sum += int'(o_rx_mismatch_count);
    end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  task automatic settle(input int n);
    cyc(n);
    @(negedge i_clk_sys);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    cyc(1);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cyc(1);
    i_rd   <= 1'b1;
    i_addr <= a;
    cyc(1);
    i_rd   <= 1'b0;
    @(negedge i_clk_sys);
    rdv    = o_rdata;
  endtask : rd
  // one tx block with slot, lane and fault controls
  task automatic tx(input logic [3:0] sel, input logic [63:0] exp, input logic usr);
    logic [63:0] d;
    d = {$urandom, $urandom};
    cyc(1);
    {i_tx_force_fault, i_tx_marker_slot, i_tx_lane} <= sel;
    i_tx_block       <= d;
    i_tx_block_valid <= 1'b1;
    cyc(1);
    i_tx_block_valid <= 1'b0;
    @(negedge i_clk_sys);
    check(o_tx_block, usr ? d : exp);
    check(o_tx_block_valid, 1'b1);
  endtask : tx
  // blocks with random flips on bits 5:0, each bit seen three times
  task automatic burst(input int n, input logic live);
    logic [63:0] m;
    repeat (n)
    begin
      m = 64'($urandom_range(63, 0));
      cyc(1);
      err <= m;
      cyc(1);
      err <= 64'h0;
      cyc(2);
      exp_sum  += live ? 3 * $countones(m) : 0;
      exp_hits += live ? int'(m != 64'h0) : 0;
    end
    cyc(6);
  endtask : burst

  initial
  begin
    #100us;
    bad_count++;
    finish_test();
  end
  initial
  begin
    void'($urandom(14));
    i_tx_lane2_align_marker = {$urandom, $urandom}; // only set under reset
    i_tx_lane3_align_marker = {$urandom, $urandom}; // only set under reset
    cyc(6);
    i_rstn <= 1'b1;
    wr(pcs_stat_pkg::OFF_CTRL, 32'h1);
    repeat (3)
    begin
      {gen, w} = i_link.scramble(pcs_stat_pkg::IDLE_BLOCK, gen);
      tx(4'h0, w, 1'b0);
    end
    tx(4'h6, i_tx_lane2_align_marker, 1'b0);
    tx(4'h7, i_tx_lane3_align_marker, 1'b0);
    tx(4'h9, pcs_stat_pkg::FAULT_BLOCK, 1'b0);
    wr(pcs_stat_pkg::OFF_CTRL, 32'h0);
    tx(4'h0, 64'h0, 1'b1);
    check(o_rx_local_fault, 1'b1);
    lk = 4'($urandom);
    cyc(1);
    i_rx_lane_lock <= lk;
    settle(2);
    check(o_rx_lane_lock, lk);
    cyc(1);
    i_rx_decoder_init <= 1'b0;
    i_rx_lane_lock    <= 4'hf;
    link_en           <= 1'b1;
    settle(2);
    check(o_rx_local_fault, 1'b0);
    wr(pcs_stat_pkg::OFF_CTRL, 32'h2);
    burst(20, 1'b1);
    check(hits, exp_hits);
    check(sum, exp_sum);
    foreach (gate[k])
    begin
      wr(pcs_stat_pkg::OFF_CTRL, 32'(gate[k][6:5]));
      i_rx_decoder_init <= gate[k][4];
      i_rx_lane_lock    <= gate[k][3:0];
      burst(6, 1'b0);
    end
    check(hits, exp_hits);
    rd(pcs_stat_pkg::OFF_MISMATCH_TOTAL);
    check(rdv, exp_sum);
    rd(pcs_stat_pkg::OFF_EVT_STATUS);
    check(rdv[pcs_stat_pkg::EVT_MISMATCH], 1'b1);
    check(o_irq, 1'b0);
    wr(pcs_stat_pkg::OFF_EVT_ENABLE, 32'h10);
    settle(1);
    check(o_irq, 1'b1);
    wr(pcs_stat_pkg::OFF_EVT_CLEAR, 32'h10);
    settle(1);
    check(o_irq, 1'b0);
    rd(8'h40);
    check(rdv, 32'h0);
    // bad headers for 40 cycles, spanning at most two windows
    cyc(1);
    i_rx_sync_hdr_valid <= 1'b1;
    i_rx_sync_hdr_bad   <= 1'b1;
    cyc(40);
    i_rx_sync_hdr_valid <= 1'b0;
    settle(2);
    check(o_rx_excess_bit_errors, 1'b1);
    settle(192);
    check(o_rx_excess_bit_errors, 1'b0);
    // fifo slip, then reset with errors on the line
    cyc(1);
    i_rx_decoder_init <= 1'b0;
    i_rx_lane_lock    <= 4'hf;
    i_rx_fifo_underflow <= 1'b1;
    cyc(1);
    i_rx_fifo_underflow <= 1'b0;
    settle(5);
    check(o_rx_fifo_error, 1'b1);
    cyc(1);
    i_rstn <= 1'b0;
    err    <= 64'h3f;
    settle(6);
    check(hits, exp_hits);
    check(o_rx_fifo_error, 1'b0);
    cyc(1);
    err    <= 64'h0;
    i_rstn <= 1'b1;
    wr(pcs_stat_pkg::OFF_CTRL, 32'h2);
    burst(4, 1'b1);
    check(sum, exp_sum);
    i_rx_fifo_overflow <= 1'b1;
    cyc(1);
    i_rx_fifo_overflow <= 1'b0;
    settle(3);
    check(o_rx_fifo_error, 1'b1);
    finish_test();
  end
endmodule : test_pcs_rx_status_test_pattern
